//--- rtl/ads_pkg.sv
// Constants and types for the asynchronous DRAM strobe sequencer
// Contract
// RULE_01: Every row is refreshed at least once per 8 ms interval.
// RULE_02: Row strobe low 80 ns to 10 000 ns outside page mode.
// RULE_03: Page mode row strobe low at most 100 000 ns, at least 80 ns.
// RULE_04: Row strobe stays high at least 60 ns between row cycles.
// RULE_05: Row cycle at least 150 ns; read-modify-write at least 205 ns.
// RULE_06: Column strobe low 20 ns to 10 000 ns; page cycles 50 ns apart.
// RULE_07: Fastest page cycle only when column setup covers column strobe high time.
// RULE_08: Column strobe falls 22 ns to 60 ns after row strobe falls.
// RULE_09: Reads end with write strobe high after column or row strobe rises.
// RULE_10: Write data held 15 ns after later of column or write strobe fall.
// RULE_11: Early write keeps write strobe low 15 ns after column strobe falls.
// RULE_12: Modify-write strobe waits 50 ns after column, 110 row, 70 address.
// RULE_13: Read-modify-write stretches both strobes to honour write strobe timing.
// RULE_14: Output enable high at least 20 ns before driving write data.
// RULE_15: Memory data is trusted only after the access time has passed.
// RULE_16: Page activations may mix reads, writes and read-modify-writes.
// RULE_17: Column-first refresh drops column strobe 10 ns before row strobe.
// RULE_18: Column-first refresh keeps column strobe low 20 ns after row fall.
// RULE_19: Write strobe low 20 ns before column rise and before row rise.
// RULE_20: After power-up wait 200 us, then eight init cycles before access.
// RULE_21: Row-only refresh cycles a row address with column strobe high.
// RULE_22: Hidden refresh keeps column strobe low across a row strobe re-cycle.
package ads_pkg;
	localparam int CLK_NS = 4;
	localparam int RC_W   = 16;

	function automatic int cyc_min(input int ns);
		return (ns + CLK_NS - 1) / CLK_NS;
	endfunction : cyc_min

	function automatic int cmax(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : cmax

	// Times as printed
	localparam int T_RAS_NS     = 80;
	localparam int T_RAS_MAX_NS = 10000;
	localparam int T_RP_NS      = 60;
	localparam int T_RC_NS      = 150;
	localparam int T_RWC_NS     = 205;
	localparam int T_CAS_NS     = 20;
	localparam int ROW_TO_COL_DELAY_NS     = 22;
	localparam int ROW_TO_COL_DELAY_MAX_NS = 60;
	localparam int T_DH_NS      = 15;
	localparam int T_CWL_NS     = 20;
	localparam int COL_TO_STORE_DELAY_NS     = 50;
	localparam int T_RWD_NS     = 110;
	localparam int T_AWD_NS     = 70;
	localparam int T_OE_REL_NS  = 20;
	localparam int REFRESH_COL_SETUP_NS     = 10;
	localparam int REFRESH_COL_HOLD_NS     = 20;
	localparam int T_RAC_NS     = 80;
	localparam int T_REF_MS     = 8;
	localparam int REF_ROWS     = 512;
	localparam int T_INIT_US    = 200;
	localparam int INIT_CYCLES  = 8;
	localparam int SYNC_C       = 2;

	// Cycle counts
	localparam int RAS_C     = cyc_min(T_RAS_NS);
	localparam int RAS_MAX_C = T_RAS_MAX_NS / CLK_NS;
	localparam int RP_C      = cyc_min(T_RP_NS);
	localparam int RC_C      = cyc_min(T_RC_NS);
	localparam int RWC_C     = cyc_min(T_RWC_NS);
	localparam int CAS_C     = cyc_min(T_CAS_NS);
	localparam int RCD_C     = cyc_min(ROW_TO_COL_DELAY_NS);
	localparam int RCD_MAX_C = ROW_TO_COL_DELAY_MAX_NS / CLK_NS;
	localparam int DH_C      = cyc_min(T_DH_NS);
	localparam int CWL_C     = cyc_min(T_CWL_NS);
	localparam int CWD_C     = cyc_min(COL_TO_STORE_DELAY_NS);
	localparam int RWD_C     = cyc_min(T_RWD_NS);
	localparam int AWD_C     = cyc_min(T_AWD_NS);
	localparam int OE_REL_C  = cyc_min(T_OE_REL_NS);
	localparam int CSR_C     = cyc_min(REFRESH_COL_SETUP_NS);
	localparam int CHR_C     = cyc_min(REFRESH_COL_HOLD_NS);
	localparam int RAC_C     = cyc_min(T_RAC_NS);
	localparam int REF_ROW_C = T_REF_MS * 1000000 / REF_ROWS / CLK_NS;
	localparam int INIT_WAIT_C = cyc_min(T_INIT_US * 1000);

	// Milestones inside a row activation, counted from the row strobe fall; refresh ones count from the column strobe fall
	localparam int COL_AT    = RCD_C - 1;
	localparam int CAS_AT    = RCD_C;
	localparam int RD_AT     = RAC_C + SYNC_C + 1;
	localparam int RW_END    = cmax(RD_AT + 1, RC_C - RP_C - 2);
	localparam int RMW_WE_AT = cmax(cmax(RD_AT + 1 + OE_REL_C, RWD_C),
		cmax(CAS_AT + CWD_C, COL_AT + AWD_C));
	localparam int RMW_END   = cmax(RMW_WE_AT + cmax(CWL_C, DH_C), RWC_C - RP_C - 2);
	localparam int CBR_CAS_END = CSR_C + CHR_C;
	// Refresh row cycle is stretched to the full cycle time as well
	localparam int CBR_END   = CSR_C + cmax(RAS_C, RC_C - RP_C - 2);

	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_RMW, OP_RONLY} ads_op_t;
	typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_ROW, ST_CBR, ST_PRE} ads_state_t;
endpackage : ads_pkg

//--- rtl/ads_ctrl.sv
// Host-side strobe sequencer for an asynchronous 256K x 4 DRAM, with read FIFO
`timescale 1ns/1ns
`default_nettype none

module ads_fifo #(
	parameter int W = 4,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0]   cnt;
	logic          wr;
	logic          rd;

	assign in_ready  = cnt != (AW+1)'(D);
	assign out_valid = cnt != '0;
	assign out_data  = mem[rp];
	assign wr        = in_valid && in_ready;
	assign rd        = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (wr) begin
			mem[wp] <= in_data;
		end
	end

	// Depth is a power of two so the pointers wrap on their own
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			if (wr) begin
				wp <= wp + AW'(1);
			end
			if (rd) begin
				rp <= rp + AW'(1);
			end
			cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule : ads_fifo

module ads_ctrl import ads_pkg::*; #(
	parameter int ROW_W  = 9,
	parameter int DQ_W   = 4,
	parameter int FIFO_D = 16,
	parameter int INIT_C = INIT_WAIT_C,
	parameter int INIT_N = INIT_CYCLES
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// User requests
	input  wire logic               req_valid,
	output logic                    req_ready,
	input  wire logic [1:0]         req_op,
	input  wire logic [2*ROW_W-1:0] req_addr,
	input  wire logic [DQ_W-1:0]    req_wdata,
	// Read data
	output logic                    rd_valid,
	input  wire logic               rd_ready,
	output logic [DQ_W-1:0]         rd_data,
	// Status
	output logic                    init_done,
	// Memory pins
	output logic                    ras_n,
	output logic                    cas_n,
	output logic                    we_n,
	output logic                    oe_n,
	output logic [ROW_W-1:0]        muxed_addr_pins,
	input  wire logic [DQ_W-1:0]    dq_i,
	output logic [DQ_W-1:0]         dq_o,
	output logic                    dq_oe
);
	ads_state_t        state;
	ads_op_t           op;
	logic [RC_W-1:0]   rc;
	logic [RC_W-1:0]   end_rc;
	logic [ROW_W-1:0]  row_a;
	logic [ROW_W-1:0]  col_a;
	logic [ROW_W-1:0]  ref_row;
	logic [DQ_W-1:0]   wdata;
	logic [3:0]        init_left;
	logic [RC_W-1:0]   ref_tmr;
	logic              ref_pend;
	logic [DQ_W-1:0]   dq_m;
	logic [DQ_W-1:0]   dq_s;
	logic              fifo_in_ready;
	logic              push;
	logic              reads;

	assign reads     = (op == OP_READ) || (op == OP_RMW);
	// Read-modify-write stretches both strobes past the late write strobe
	assign end_rc    = (op == OP_RMW) ? RC_W'(RMW_END) : RC_W'(RW_END); // RULE_13
	assign init_done = (state != ST_INIT) && (init_left == '0);
	// Reads are only taken while the FIFO can hold their word
	assign req_ready = (state == ST_IDLE) && init_done && !ref_pend
		&& (req_op == OP_WRITE || fifo_in_ready);
	// Sampled one clock past the access time plus the synchroniser
	assign push      = (state == ST_ROW) && (rc == RC_W'(RD_AT)) && reads; // RULE_15

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dq_m <= '0;
			dq_s <= '0;
		end else begin
			dq_m <= dq_i;
			dq_s <= dq_m;
		end
	end

	// Sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state     <= ST_INIT;
			rc        <= '0;
			op        <= OP_READ;
			row_a     <= '0;
			col_a     <= '0;
			wdata     <= '0;
			ref_row   <= '0;
			init_left <= 4'(INIT_N);
		end else begin
			rc <= rc + RC_W'(1);
			case (state)
				ST_INIT: begin
					if (rc == RC_W'(INIT_C - 1)) begin // RULE_20
						state <= ST_IDLE;
						rc    <= '0;
					end
				end
				ST_IDLE: begin
					rc <= '0;
					if (init_left != '0) begin // RULE_20
						state     <= ST_ROW;
						op        <= OP_RONLY; // RULE_21
						row_a     <= ref_row;
						ref_row   <= ref_row + 1'b1;
						init_left <= init_left - 4'(1);
					end else if (ref_pend) begin // RULE_01
						// Standalone refresh only; no hidden refresh after a read
						state <= ST_CBR; // RULE_22
					end else if (req_valid && req_ready) begin
						state <= ST_ROW;
						op    <= ads_op_t'(req_op); // RULE_16
						row_a <= req_addr[2*ROW_W-1:ROW_W];
						col_a <= req_addr[ROW_W-1:0];
						wdata <= req_wdata;
					end
				end
				ST_ROW: begin
					if (rc == end_rc) begin
						state <= ST_PRE;
						rc    <= '0;
					end
				end
				ST_CBR: begin
					if (rc == RC_W'(CBR_END)) begin
						state <= ST_PRE;
						rc    <= '0;
					end
				end
				ST_PRE: begin
					if (rc == RC_W'(RP_C - 1)) begin // RULE_04
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Refresh pacing: one column-first refresh per row slot
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_tmr  <= '0;
			ref_pend <= 1'b0;
		end else begin
			ref_tmr <= (ref_tmr == RC_W'(REF_ROW_C - 1)) ? '0 : ref_tmr + RC_W'(1);
			if (ref_tmr == RC_W'(REF_ROW_C - 1)) begin // RULE_01
				ref_pend <= 1'b1;
			end else if (state == ST_IDLE && init_done && ref_pend) begin
				ref_pend <= 1'b0;
			end
		end
	end

	// Pins follow the sequencer one cycle late, all shifted alike
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ras_n           <= 1'b1;
			cas_n           <= 1'b1;
			we_n            <= 1'b1;
			oe_n            <= 1'b1;
			muxed_addr_pins <= '0;
			dq_o            <= '0;
			dq_oe           <= 1'b0;
		end else begin
			ras_n           <= 1'b1;
			cas_n           <= 1'b1;
			we_n            <= 1'b1;
			oe_n            <= 1'b1;
			dq_oe           <= 1'b0;
			muxed_addr_pins <= row_a;
			dq_o            <= wdata;
			case (state)
				ST_ROW: begin
					ras_n <= rc == end_rc; // RULE_02
					if (op != OP_RONLY) begin
						if (rc >= RC_W'(COL_AT)) begin
							muxed_addr_pins <= col_a; // RULE_07
						end
						cas_n <= !(rc >= RC_W'(CAS_AT) && rc < end_rc); // RULE_08
						oe_n  <= !(reads && rc >= RC_W'(CAS_AT) && rc <= RC_W'(RD_AT));
						if (op == OP_WRITE) begin
							// Early write: strobe low before the column strobe
							we_n  <= !(rc >= RC_W'(COL_AT) && rc < end_rc); // RULE_11
							dq_oe <= rc >= RC_W'(COL_AT); // RULE_10
						end
						if (op == OP_RMW) begin
							we_n  <= !(rc >= RC_W'(RMW_WE_AT) && rc < end_rc); // RULE_12
							dq_oe <= rc >= RC_W'(RMW_WE_AT); // RULE_14
						end
					end
				end
				ST_CBR: begin
					cas_n <= !(rc < RC_W'(CBR_CAS_END)); // RULE_18
					ras_n <= !(rc >= RC_W'(CSR_C) && rc < RC_W'(CBR_END)); // RULE_17
				end
				default: ;
			endcase
		end
	end

	ads_fifo #(
		.W(DQ_W),
		.D(FIFO_D)
	) u_rd_fifo (
		.clk      (clk),
		.rst      (rst),
		.in_valid (push),
		.in_ready (fifo_in_ready),
		.in_data  (dq_s),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data (rd_data)
	);

	// Pin timing watchers for the assertions
	logic [RC_W-1:0] ras_lo;
	logic [RC_W-1:0] ras_hi;
	logic [RC_W-1:0] cas_lo;
	logic [RC_W-1:0] we_lo;
	logic [RC_W-1:0] oe_hi;
	logic [RC_W-1:0] gap;
	logic            last_rmw;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ras_lo   <= '0;
			ras_hi   <= '0;
			cas_lo   <= '0;
			we_lo    <= '0;
			oe_hi    <= '0;
			gap      <= '1;
			last_rmw <= 1'b0;
		end else begin
			ras_lo <= ras_n ? '0 : ras_lo + RC_W'(1);
			ras_hi <= !ras_n ? '0 : ras_hi + RC_W'(!(&ras_hi));
			cas_lo <= cas_n ? '0 : cas_lo + RC_W'(1);
			we_lo  <= we_n ? '0 : we_lo + RC_W'(1);
			oe_hi  <= !oe_n ? '0 : oe_hi + RC_W'(!(&oe_hi));
			gap    <= (!ras_n && ras_lo == '0) ? RC_W'(1) : gap + RC_W'(!(&gap));
			if (!ras_n && ras_lo == '0) begin
				last_rmw <= (state == ST_ROW) && (op == OP_RMW);
			end
		end
	end

	a_ras_low_min: assert property (@(posedge clk) disable iff (rst) // RULE_02
		$rose(ras_n) |-> ras_lo >= RC_W'(RAS_C)) else $error("row strobe low too short");
	a_ras_low_max: assert property (@(posedge clk) disable iff (rst) // RULE_02
		!ras_n |-> ras_lo < RC_W'(RAS_MAX_C)) else $error("row strobe low too long");
	a_precharge: assert property (@(posedge clk) disable iff (rst) // RULE_04
		$fell(ras_n) |-> ras_hi >= RC_W'(RP_C)) else $error("precharge too short");
	a_row_period: assert property (@(posedge clk) disable iff (rst) // RULE_05
		$fell(ras_n) |-> gap >= (last_rmw ? RC_W'(RWC_C) : RC_W'(RC_C)))
		else $error("row cycle too short");
	a_cas_width: assert property (@(posedge clk) disable iff (rst) // RULE_06
		$rose(cas_n) |-> cas_lo >= RC_W'(CAS_C)) else $error("column strobe too short");
	a_row_to_col: assert property (@(posedge clk) disable iff (rst) // RULE_08
		$fell(cas_n) && !ras_n |-> ras_lo >= RC_W'(RCD_C) && ras_lo <= RC_W'(RCD_MAX_C))
		else $error("row to column delay out of range");
	a_read_end: assert property (@(posedge clk) disable iff (rst) // RULE_09
		$rose(cas_n) && op == OP_READ |-> we_n && $past(we_n))
		else $error("write strobe low at read end");
	a_data_hold: assert property (@(posedge clk) disable iff (rst) // RULE_10
		$fell(cas_n) && !we_n |-> (!we_n && dq_oe) [*4])
		else $error("early write data or strobe not held");
	a_rmw_we: assert property (@(posedge clk) disable iff (rst) // RULE_12
		$fell(we_n) && !cas_n |-> cas_lo >= RC_W'(CWD_C) && ras_lo >= RC_W'(RWD_C))
		else $error("modify write strobe too early");
	a_oe_release: assert property (@(posedge clk) disable iff (rst) // RULE_14
		$rose(dq_oe) |-> oe_n && oe_hi >= RC_W'(OE_REL_C))
		else $error("data driven before output release");
	a_cbr_setup: assert property (@(posedge clk) disable iff (rst) // RULE_17
		$fell(ras_n) && !cas_n |-> cas_lo >= RC_W'(CSR_C))
		else $error("refresh column setup too short");
	a_cbr_hold: assert property (@(posedge clk) disable iff (rst) // RULE_18
		$fell(ras_n) && !cas_n |-> !cas_n [*5]) else $error("refresh column hold too short");
	a_we_setup: assert property (@(posedge clk) disable iff (rst) // RULE_19
		($rose(cas_n) || $rose(ras_n)) && $past(!we_n) |-> $past(we_lo) >= RC_W'(CWL_C - 1))
		else $error("write strobe low too short before rise");
	a_refresh_due: assert property (@(posedge clk) disable iff (rst) // RULE_01
		$rose(ref_pend) && init_done |-> ##[1:64] (state == ST_CBR))
		else $error("refresh not issued in time");
endmodule : ads_ctrl

`default_nettype wire

//--- tb/ads_mem_model.sv
// Behavioural 256K x 4 DRAM that also times the strobes it sees
`timescale 1ns/1ns
`default_nettype none

module ads_mem_model (
	// Strobes and address
	input  wire logic       ras_n,
	input  wire logic       cas_n,
	input  wire logic       we_n,
	input  wire logic       oe_n,
	input  wire logic [8:0] addr,
	// Data pins
	input  wire logic [3:0] dq_o,
	input  wire logic       dq_oe,
	output logic [3:0]      dq_i,
	// Tallies
	output int              n_viol,
	output int              n_cbr,
	output int              n_ronly
);
	logic [3:0] mem [logic [17:0]];
	logic [8:0] row, col;
	logic [3:0] rdw = 4'h0;
	logic       vr = 1'b0, vc = 1'b0, cbr = 1'b0, used = 1'b0;
	time        t_rf = 0, t_rr = 0, t_cf = 0, t_wf = 0, t_oh = 0;

	initial begin
		n_viol = 0;
		n_cbr = 0;
		n_ronly = 0;
	end

	task automatic store();
		logic [3:0] d;
		// Strobe and data enable change in one step; let both settle
		#1 d = dq_oe ? dq_o : 4'hx;
		mem[{row, col}] = d;
		#15 if (!dq_oe || dq_o !== d) n_viol++;
	endtask : store

	always @(negedge ras_n) begin
		if ($time - t_rr < 60) n_viol++;
		if (t_rf > 0 && !cbr && $time - t_rf < 150) n_viol++;
		t_rf = $time;
		used = 1'b0;
		cbr = !cas_n;
		if (cbr && $time - t_cf < 10) n_viol++;
		n_cbr += int'(cbr);
		vr = 1'b0;
		#80 vr = !ras_n;
	end

	// Row address lands in the same step as the strobe
	always @(negedge ras_n) #1 row = addr;

	// Startup edges out of X carry no timing meaning
	always @(posedge ras_n) if (t_rf > 0) begin
		if ($time - t_rf < 80 || $time - t_rf > 10000) n_viol++;
		if (!we_n && $time - t_wf < 20) n_viol++;
		if (!used && !cbr) n_ronly++;
		t_rr = $time;
	end

	always @(negedge cas_n) begin
		t_cf = $time;
		vc = 1'b0;
		if (!ras_n) begin
			if ($time - t_rf < 22 || $time - t_rf > 60) n_viol++;
			used = 1'b1;
			col = addr;
			rdw = mem.exists({row, col}) ? mem[{row, col}] : 4'h0;
			if (!we_n) store();
		end
		#20 vc = !cas_n;
	end

	always @(negedge we_n) begin
		t_wf = $time;
		if (!ras_n && !cas_n) begin
			if ($time - t_cf < 50 || $time - t_rf < 110) n_viol++;
			store();
		end
	end

	always @(posedge cas_n) if (t_cf > 0) begin
		if ($time - t_cf < 20 || (cbr && $time - t_rf < 20)) n_viol++;
		if (!we_n && $time - t_wf < 20) n_viol++;
		vc = 1'b0;
	end

	always @(posedge oe_n) t_oh = $time;
	always @(posedge dq_oe) if (!oe_n || $time - t_oh < 20) n_viol++;

	// Released bus shows the inverse of the last word, never a stale match
	always @* begin
		if (dq_oe) dq_i = dq_o;
		else if (!ras_n && !cas_n && !oe_n && we_n) dq_i = (vr && vc) ? rdw : ~rdw;
		else dq_i = ~rdw;
	end
endmodule : ads_mem_model

`default_nettype wire

//--- tb/ads_ctrl_tb_top.sv
// Self-checking bench for the DRAM strobe sequencer
`timescale 1ns/1ns
`default_nettype none

module ads_ctrl_tb_top;
	logic        clk = 1'b0, rst = 1'b1;
	logic        req_valid = 1'b0, rd_ready = 1'b0;
	logic [1:0]  req_op = 2'h0;
	logic [17:0] req_addr = 18'h0;
	logic [3:0]  req_wdata = 4'h0;
	logic        req_ready, rd_valid, init_done;
	logic        ras_n, cas_n, we_n, oe_n, dq_oe;
	logic [3:0]  rd_data, dq_i, dq_o;
	logic [8:0]  maddr;
	int          n_errors = 0, checked = 0, n_viol, n_cbr, n_ronly;

	ads_ctrl #(.INIT_C(20)) ads_ctrl_i (
		.clk(clk), .rst(rst),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
		.req_addr(req_addr), .req_wdata(req_wdata),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
		.init_done(init_done),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
		.muxed_addr_pins(maddr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe)
	);

	ads_mem_model ads_mem_model_i (
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .addr(maddr),
		.dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
		.n_viol(n_viol), .n_cbr(n_cbr), .n_ronly(n_ronly)
	);

	task automatic tally_and_finish();
		if (n_errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	task automatic cmp4(input string what, input logic [3:0] exp, input logic [3:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp4

	task automatic cmpi(input string what, input int exp, input int got);
		checked++;
		if (got != exp) begin
			n_errors++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask : cmpi

	// Request held until ready is seen high at a settled half cycle
	task automatic req(input logic [1:0] op, input logic [17:0] a, input logic [3:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req_op    <= op;
		req_addr  <= a;
		req_wdata <= d;
		do begin
			@(negedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 6000);
		cmpi("request taken", 1, int'(n < 6000));
		@(posedge clk);
		req_valid <= 1'b0;
	endtask : req

	task automatic pop(input logic [3:0] exp);
		int n;
		n = 0;
		@(posedge clk);
		rd_ready <= 1'b1;
		do begin
			@(negedge clk);
			n++;
		end while (rd_valid !== 1'b1 && n < 200);
		cmpi("rd_valid", 1, int'(rd_valid === 1'b1));
		cmp4("rd_data", exp, rd_data);
		@(posedge clk);
		rd_ready <= 1'b0;
	endtask : pop

	function automatic logic [17:0] adr(input int i);
		return {9'(i * 37), 9'(9'h1ff - i)};
	endfunction : adr

	initial begin
		forever #2 clk = ~clk;
	end

	initial begin
		#100000;
		$display("ERROR watchdog expected finish seen hang");
		n_errors++;
		tally_and_finish();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		cmp4("req_ready in init", 4'h0, {3'h0, req_ready});
		for (int n = 0; n < 1000 && init_done !== 1'b1; n++) @(negedge clk);
		cmp4("init_done", 4'h1, {3'h0, init_done});
		for (int n = 0; n < 200 && n_ronly < 8; n++) @(negedge clk);
		cmpi("row-only cycles", 8, n_ronly);
		for (int i = 0; i < 16; i++) req(2'h1, adr(i), 4'(i + 3));
		req(2'h2, adr(0), 4'ha);
		for (int i = 1; i < 16; i++) req(2'h0, adr(i), 4'h0);
		repeat (80) @(posedge clk);
		@(negedge clk);
		cmp4("req_ready full", 4'h0, {3'h0, req_ready});
		req(2'h1, adr(1), 4'hc);
		pop(4'h3);
		for (int i = 1; i < 16; i++) pop(4'(i + 3));
		req(2'h0, adr(0), 4'h0);
		req(2'h0, adr(1), 4'h0);
		pop(4'ha);
		pop(4'hc);
		req(2'h3, adr(5), 4'h0);
		for (int n = 0; n < 100 && n_ronly < 9; n++) @(negedge clk);
		cmpi("row-only cycles", 9, n_ronly);
		for (int n = 0; n < 5000 && n_cbr == 0; n++) @(negedge clk);
		cmpi("refresh seen", 1, int'(n_cbr > 0));
		req(2'h0, adr(2), 4'h0);
		pop(4'h5);
		cmpi("pin timing faults", 0, n_viol);
		tally_and_finish();
	end
endmodule : ads_ctrl_tb_top

`default_nettype wire
